/* shared/crpm_pkg.sv */
// crpm_pkg: register map, field positions, reset values and state types of the clock-run / pm control block
// assumes one pci clock domain and a classic 32-bit wishbone slave for the registers
// Behaviour
// - second interrupt pin becomes the clock-run pin only in minipci mode, never interrupting there
// - while the host holds clock-run low the device leaves its driver off
// - with protection active, drive clock-run low two clocks after the host deasserts it
// - the low pulse lasts exactly two clocks, then the line is released; repeats per request
// - misc control bits 30 (disable) and 29 (pm control), reset 0, written by bus or eeprom
// - field 00 always blocks, 01 follows pm state, 10 and 11 disable protection
// - after reset in minipci mode protection is on and every stop request is blocked
// - with protection disabled the device leaves the next host deassertion alone
// - writing 0 to the disable bit resumes blocking once the write completes
// - under pm control protection stays on while either function is in d0
// - under pm control protection drops only when both functions are in d2 or d3
// - a wake event re-enables protection at once
// - after a wake, protection drops again only after both returned to d0 and re-lowered
// - low-power wake sources: cts and ring inputs for function 0, pin two for function 1
// - in d3cold on aux power: ring inputs for function 0, pin two for function 1
// - capability bit 15 reports d3cold wake in minipci mode only
// - in pci mode a pci reset clears all pm status and wake context
// - in minipci mode a pci reset keeps wake-enable bit 8 and wake-status bit 15
// - wake bits survive the soft reset of a function restored from d3hot
// - a wake raised in d3cold stays asserted through reset until the host writes the bits
// - a line held permanently low means clock always running; the device never drives it
package crpm_pkg;

  // register byte offsets
  localparam logic [7:0] MISC_CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS    = 8'h04;
  localparam logic [7:0] PMCSR0_OFS    = 8'h08;
  localparam logic [7:0] PMCSR1_OFS    = 8'h0c;
  localparam logic [7:0] PMC_CAP_OFS   = 8'h10;

  // field positions
  localparam int CR_FIELD_LSB   = 29;
  localparam int PSTATE_LSB     = 0;
  localparam int PME_EN_BIT     = 8;
  localparam int PME_STATUS_BIT = 15;
  localparam int D3COLD_CAP_BIT = 15;

  // clock-run field values and reset
  localparam logic [1:0] CR_ALWAYS   = 2'h0;
  localparam logic [1:0] CR_PM_CTRL  = 2'h1;
  localparam logic [1:0] CR_CTRL_RST = 2'h0;

  // power states
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D2 = 2'h2;
  localparam logic [1:0] PS_D3 = 2'h3;

  // timing in pci clocks
  localparam logic [1:0] CR_DELAY_CYC = 2'h2;
  localparam logic [1:0] CR_PULSE_CYC = 2'h2;

  localparam int UART_COUNT = 4;

  typedef enum logic [1:0] {CR_IDLE = 2'b00, CR_WAIT = 2'b01, CR_DRIVE = 2'b10, CR_RELEASE = 2'b11} crpm_cr_t;
  typedef enum logic [1:0] {PM_ARMED = 2'b00, PM_RELEASED = 2'b01, PM_WOKEN = 2'b10} crpm_pm_t;

  typedef struct packed {
    logic [UART_COUNT-1:0] cts;
    logic [UART_COUNT-1:0] ring;
    logic                  pin_two;
  } crpm_wake_t;

  typedef struct packed {
    logic [1:0]      ctrl;
    crpm_cr_t        cr;
    logic [1:0]      cr_cnt;
    crpm_pm_t        pm;
    logic [1:0][1:0] pstate;
    logic [1:0]      pme_en;
    logic [1:0]      pme_st;
    logic [1:0]      wake_prev;
    logic            ack;
    logic [31:0]     rdat;
  } crpm_state_t;

endpackage

/* core/crpm_core.sv */
// crpm_core: clock-run protection, pm-driven enable, wake context and wishbone register slave
// assumes all inputs synchronous to the pci clock; rst_i is the pci reset, por_i the power-on reset
//
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps

module crpm_core
  import crpm_pkg::*;
(
  // clock and resets
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        por_i,
  // straps and power
  input  wire logic        minipci_mode_i,
  input  wire logic        aux_power_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // eeprom download of the clock-run field
  input  wire logic        eeprom_load_i,
  input  wire logic [1:0]  eeprom_ctrl_i,
  // second interrupt pin: clock-run in minipci mode, function 1 interrupt otherwise
  input  wire logic        second_interrupt_pin_i,
  output logic             second_interrupt_pin_o,
  output logic             second_interrupt_pin_oe_n_o,
  input  wire logic        fn1_irq_i,
  // wake sources and wake output
  input  wire crpm_wake_t  wake_src_i,
  output logic             pme_o,
  output logic             pme_oe_n_o,
  output logic             protect_o
);

  crpm_state_t st_reg;
  crpm_state_t st_next;

  logic       protect;
  logic       cr_drive;
  logic       wr_acc;
  logic       rd_acc;
  logic [1:0] wake_lvl;
  logic [1:0] wake_evt;
  logic [1:0] low_power;
  logic       both_low;
  logic       any_d0;
  logic [1:0] w1c;

  // effective protection; pm mode keeps it on except in the released state
  always_comb begin
    protect = 1'b0;
    if (minipci_mode_i) begin
      if (st_reg.ctrl == CR_ALWAYS) begin
        protect = 1'b1;
      end else if (st_reg.ctrl == CR_PM_CTRL) begin
        protect = (st_reg.pm != PM_RELEASED);
      end
    end
  end

  // only the drive state pulls the line; pci mode never reaches it
  assign cr_drive = minipci_mode_i && (st_reg.cr == CR_DRIVE);

  always_comb begin
    second_interrupt_pin_o      = 1'b0;
    second_interrupt_pin_oe_n_o = 1'b1;
    if (minipci_mode_i) begin
      second_interrupt_pin_oe_n_o = !cr_drive;
    end else begin
      second_interrupt_pin_oe_n_o = !fn1_irq_i;
    end
  end

  // wake sources per function; on aux power only the ring inputs count for function 0
  always_comb begin
    wake_lvl[0] = |wake_src_i.ring;
    if (!aux_power_i) begin
      wake_lvl[0] = wake_lvl[0] | (|wake_src_i.cts);
    end
    wake_lvl[1] = wake_src_i.pin_two;
  end

  generate
    for (genvar f = 0; f < 2; f++) begin : g_fn
      assign low_power[f] = (st_reg.pstate[f] != PS_D0);
      assign wake_evt[f]  = wake_lvl[f] && !st_reg.wake_prev[f] && low_power[f] && st_reg.pme_en[f];
    end
  endgenerate

  assign both_low = ((st_reg.pstate[0] == PS_D2) || (st_reg.pstate[0] == PS_D3))
                 && ((st_reg.pstate[1] == PS_D2) || (st_reg.pstate[1] == PS_D3));
  assign any_d0   = !low_power[0] || !low_power[1];

  // a write takes effect on the edge where ack is seen high
  assign wr_acc = wb_cyc_i && wb_stb_i && st_reg.ack && wb_we_i;
  assign rd_acc = wb_cyc_i && wb_stb_i && !st_reg.ack;

  always_comb begin
    st_next           = st_reg;
    st_next.wake_prev = wake_lvl;
    w1c               = 2'b00;

    // clock-run sequencer
    unique case (st_reg.cr)
      CR_IDLE: begin
        if (minipci_mode_i && second_interrupt_pin_i && protect) begin
          st_next.cr     = CR_WAIT;
          st_next.cr_cnt = 2'h0;
        end
      end
      CR_WAIT: begin
        if (st_reg.cr_cnt == CR_DELAY_CYC - 2'h2) begin
          st_next.cr     = CR_DRIVE;
          st_next.cr_cnt = 2'h0;
        end else begin
          st_next.cr_cnt = st_reg.cr_cnt + 2'h1;
        end
      end
      CR_DRIVE: begin
        if (st_reg.cr_cnt == CR_PULSE_CYC - 2'h1) begin
          st_next.cr = CR_RELEASE;
        end else begin
          st_next.cr_cnt = st_reg.cr_cnt + 2'h1;
        end
      end
      CR_RELEASE: begin
        // one quiet cycle lets the host's own low drive settle before re-arming
        st_next.cr = CR_IDLE;
      end
    endcase

    // pm-driven protection
    unique case (st_reg.pm)
      PM_ARMED: begin
        if (both_low) begin
          st_next.pm = PM_RELEASED;
        end
      end
      PM_RELEASED: begin
        if (|wake_evt) begin
          st_next.pm = PM_WOKEN;
        end else if (any_d0) begin
          st_next.pm = PM_ARMED;
        end
      end
      PM_WOKEN: begin
        if (!low_power[0] && !low_power[1]) begin
          st_next.pm = PM_ARMED;
        end
      end
      default: st_next.pm = PM_ARMED;
    endcase

    if (eeprom_load_i) begin
      st_next.ctrl = eeprom_ctrl_i;
    end

    if (wr_acc) begin
      unique case (wb_adr_i)
        MISC_CTRL_OFS: begin
          if (wb_sel_i[3]) begin
            st_next.ctrl = wb_dat_i[CR_FIELD_LSB +: 2];
          end
        end
        PMCSR0_OFS, PMCSR1_OFS: begin
          // byte 0 sets the power state; byte 1 of the same write sets wake enable and clears wake status on a one
          if (wb_sel_i[0]) begin
            st_next.pstate[wb_adr_i[2]] = wb_dat_i[PSTATE_LSB +: 2];
          end
          if (wb_sel_i[1]) begin
            st_next.pme_en[wb_adr_i[2]] = wb_dat_i[PME_EN_BIT];
            w1c[wb_adr_i[2]]            = wb_dat_i[PME_STATUS_BIT];
          end
        end
        default: ;
      endcase
    end

    // a wake that lands with a clear still sets the status
    st_next.pme_st = (st_reg.pme_st & ~w1c) | wake_evt;

    st_next.ack = wb_cyc_i && wb_stb_i && !st_reg.ack;
    if (rd_acc) begin
      unique case (wb_adr_i)
        MISC_CTRL_OFS: st_next.rdat = 32'(st_reg.ctrl) << CR_FIELD_LSB;
        STATUS_OFS:    st_next.rdat = {24'h0, st_reg.cr, st_reg.pm, protect, cr_drive, minipci_mode_i, aux_power_i};
        PMCSR0_OFS, PMCSR1_OFS: begin
          st_next.rdat                            = 32'h0;
          st_next.rdat[PSTATE_LSB +: 2]          = st_reg.pstate[wb_adr_i[2]];
          st_next.rdat[PME_EN_BIT]               = st_reg.pme_en[wb_adr_i[2]];
          st_next.rdat[PME_STATUS_BIT]           = st_reg.pme_st[wb_adr_i[2]];
        end
        PMC_CAP_OFS: st_next.rdat = 32'(minipci_mode_i) << D3COLD_CAP_BIT;
        default:     st_next.rdat = 32'h0;
      endcase
    end

    if (rst_i) begin
      st_next        = '0;
      st_next.ctrl   = CR_CTRL_RST;
      st_next.cr     = CR_IDLE;
      st_next.pm     = PM_ARMED;
      st_next.pstate = {PS_D0, PS_D0};
      // minipci keeps the wake context through pci reset; pci mode and power-on lose it
      if (minipci_mode_i && !por_i) begin
        st_next.pme_en = st_reg.pme_en;
        st_next.pme_st = st_reg.pme_st;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    st_reg <= st_next;
  end

  assign wb_ack_o   = st_reg.ack;
  assign wb_dat_o   = st_reg.rdat;
  assign pme_o      = 1'b0;
  assign pme_oe_n_o = !(|(st_reg.pme_st & st_reg.pme_en));
  assign protect_o  = protect;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_delay_pulse;
    (st_reg.cr == CR_IDLE && minipci_mode_i && second_interrupt_pin_i && protect)
      |-> !cr_drive ##1 !cr_drive ##1 cr_drive ##1 cr_drive ##1 !cr_drive;
  endproperty
  a_delay_pulse: assert property (p_delay_pulse) else $error("clock-run pulse not two clocks after deassert");

  property p_pulse_len;
    $rose(cr_drive) |=> cr_drive ##1 !cr_drive;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("clock-run pulse not exactly two clocks");

  property p_host_low_quiet;
    (st_reg.cr == CR_IDLE && !second_interrupt_pin_i) |=> !cr_drive ##1 !cr_drive;
  endproperty
  a_host_low_quiet: assert property (p_host_low_quiet) else $error("line driven while host holds it low");

  property p_pci_mode_no_drive;
    !minipci_mode_i |-> (second_interrupt_pin_oe_n_o == !fn1_irq_i);
  endproperty
  a_pci_mode_no_drive: assert property (p_pci_mode_no_drive) else $error("pin misused in pci mode");

  property p_disabled_no_block;
    (st_reg.ctrl[1] && st_reg.cr == CR_IDLE) |=> !cr_drive ##1 !cr_drive;
  endproperty
  a_disabled_no_block: assert property (p_disabled_no_block) else $error("blocked stop while disabled");

  property p_pm_release;
    (minipci_mode_i && st_reg.ctrl == CR_PM_CTRL && st_reg.pm == PM_ARMED && both_low && !eeprom_load_i && !wr_acc)
      |=> !protect;
  endproperty
  a_pm_release: assert property (p_pm_release) else $error("protection kept with both functions low");

  property p_pm_d0_protect;
    (minipci_mode_i && st_reg.ctrl == CR_PM_CTRL && any_d0 && !eeprom_load_i && !wr_acc) |=> protect;
  endproperty
  a_pm_d0_protect: assert property (p_pm_d0_protect) else $error("protection off with a function in d0");

  property p_wake_protect;
    (st_reg.pm == PM_RELEASED && |wake_evt) |=> (st_reg.pm == PM_WOKEN) ##1 (st_reg.pm != PM_RELEASED);
  endproperty
  a_wake_protect: assert property (p_wake_protect) else $error("wake did not re-arm protection");

  property p_woken_holds;
    (st_reg.pm == PM_WOKEN && (low_power[0] || low_power[1])) |=> (st_reg.pm == PM_WOKEN);
  endproperty
  a_woken_holds: assert property (p_woken_holds) else $error("left woken state before both in d0");

  property p_w1c;
    (wr_acc && wb_adr_i == PMCSR0_OFS && wb_sel_i[1] && wb_dat_i[PME_STATUS_BIT] && !wake_evt[0])
      |=> !st_reg.pme_st[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("wake status not cleared by write of one");

  property p_keep_ctx;
    disable iff (por_i)
    (rst_i && minipci_mode_i) |=> (st_reg.pme_st == $past(st_reg.pme_st)) && (st_reg.pme_en == $past(st_reg.pme_en));
  endproperty
  a_keep_ctx: assert property (p_keep_ctx) else $error("wake context lost across pci reset");

  property p_pci_clear;
    disable iff (1'b0)
    (rst_i && !minipci_mode_i) |=> (st_reg.pme_st == 2'b00) && (st_reg.pme_en == 2'b00);
  endproperty
  a_pci_clear: assert property (p_pci_clear) else $error("wake context kept in pci mode");

  property p_cap;
    (wb_cyc_i && wb_stb_i && !st_reg.ack && wb_adr_i == PMC_CAP_OFS)
      |=> (wb_dat_o[D3COLD_CAP_BIT] == $past(minipci_mode_i));
  endproperty
  a_cap: assert property (p_cap) else $error("d3cold capability bit wrong");

  property p_ctrl_write;
    (wr_acc && wb_adr_i == MISC_CTRL_OFS && wb_sel_i[3]) |=> (st_reg.ctrl == $past(wb_dat_i[CR_FIELD_LSB +: 2]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("clock-run field not taken from bus write");

  property p_eeprom_load;
    (eeprom_load_i && !wr_acc) |=> (st_reg.ctrl == $past(eeprom_ctrl_i));
  endproperty
  a_eeprom_load: assert property (p_eeprom_load) else $error("clock-run field not taken from eeprom");

  property p_resume;
    (minipci_mode_i && wr_acc && wb_adr_i == MISC_CTRL_OFS && wb_sel_i[3]
      && wb_dat_i[CR_FIELD_LSB +: 2] == CR_ALWAYS) |=> protect;
  endproperty
  a_resume: assert property (p_resume) else $error("protection not back after enable write");

  property p_unprotected_idle;
    (!protect && st_reg.cr == CR_IDLE) |=> (st_reg.cr == CR_IDLE);
  endproperty
  a_unprotected_idle: assert property (p_unprotected_idle) else $error("sequencer left idle without protection");

  property p_wake_sets;
    (|wake_evt) |=> ((st_reg.pme_st & $past(wake_evt)) == $past(wake_evt));
  endproperty
  a_wake_sets: assert property (p_wake_sets) else $error("wake event did not set status");

  property p_aux_ring_only;
    (aux_power_i && !(|wake_src_i.ring)) |-> !wake_lvl[0];
  endproperty
  a_aux_ring_only: assert property (p_aux_ring_only) else $error("non-ring source woke function 0 on aux");

  property p_wake_through_reset;
    disable iff (por_i)
    (rst_i && minipci_mode_i && !pme_oe_n_o) |=> !pme_oe_n_o;
  endproperty
  a_wake_through_reset: assert property (p_wake_through_reset) else $error("wake output dropped by pci reset");

  property p_w1c_zero;
    (wr_acc && wb_adr_i == PMCSR1_OFS && wb_sel_i[1] && !wb_dat_i[PME_STATUS_BIT] && st_reg.pme_st[1])
      |=> st_reg.pme_st[1];
  endproperty
  a_w1c_zero: assert property (p_w1c_zero) else $error("wake status cleared by write of zero");

  property p_cov_block;
    $rose(cr_drive);
  endproperty
  c_block: cover property (p_cov_block);

  property p_cov_release;
    st_reg.pm == PM_ARMED ##1 st_reg.pm == PM_RELEASED;
  endproperty
  c_release: cover property (p_cov_release);

  property p_cov_wake;
    st_reg.pm == PM_RELEASED ##1 st_reg.pm == PM_WOKEN;
  endproperty
  c_wake: cover property (p_cov_wake);

  property p_cov_stop_allowed;
    st_reg.ctrl[1] && second_interrupt_pin_i && st_reg.cr == CR_IDLE;
  endproperty
  c_stop_allowed: cover property (p_cov_stop_allowed);

  property p_cov_rearm;
    st_reg.pm == PM_WOKEN ##1 st_reg.pm == PM_ARMED;
  endproperty
  c_rearm: cover property (p_cov_rearm);

endmodule // crpm_core

/* verification/crpm_host.sv */
// crpm_host: host-side model of the clock-run line, making one stop attempt per request
// assumes the device pin is open-drain on a pulled-up line and shares the pci clock
`timescale 1ns/1ps

module crpm_host (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // stop request from the bench and device pull-down
  input  wire logic       req_i,
  input  wire logic       dev_oe_n_i,
  // line level and attempt result
  output logic            line_o,
  output logic            done_o,
  output logic            blocked_o,
  output logic      [3:0] lat_o
);
  logic [1:0] phase_reg;
  logic [3:0] cnt_reg;

  // drive high one cycle, then release; the pull-up keeps it high unless the device pulls it
  assign line_o = (phase_reg == 2'h1) ? 1'b1 : (phase_reg == 2'h2) ? dev_oe_n_i : 1'b0;

  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      phase_reg <= 2'h0;
      cnt_reg   <= 4'h0;
      blocked_o <= 1'b0;
      lat_o     <= 4'h0;
    end else begin
      case (phase_reg)
        2'h0: if (req_i) begin
          phase_reg <= 2'h1;
          cnt_reg   <= 4'h0;
        end
        2'h1: begin
          phase_reg <= 2'h2;
          cnt_reg   <= cnt_reg + 4'h1;
        end
        default: if (!dev_oe_n_i) begin
          // take the line low ourselves while the device pulse is on, and keep it there
          lat_o     <= cnt_reg;
          blocked_o <= 1'b1;
          done_o    <= 1'b1;
          phase_reg <= 2'h0;
        end else if (cnt_reg == 4'h8) begin
          // no pull within the window: the clock would stop; restart it at once
          blocked_o <= 1'b0;
          done_o    <= 1'b1;
          phase_reg <= 2'h0;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      endcase
    end
  end
endmodule // crpm_host

/* verification/crpm_core_bench.sv */
// crpm_core_bench: wishbone register tasks and stop attempts against crpm_core with a host model
// assumes the package offsets and the one-cycle ack of the register slave
`timescale 1ns/1ps

module crpm_core_bench;
  import crpm_pkg::*;
  logic        clk_i, rst_i, por_i, mini, aux, cyc, stb, we, eload, irq, req;
  logic [7:0]  adr;
  logic [3:0]  sel, lat;
  logic [31:0] wdat, dat_r, rd;
  logic [1:0]  ectrl;
  logic        ack, cr_o, oe_n, pme_o, pme_oe_n, prot, line, done, blk;
  crpm_wake_t  wake;
  int          fails, compares, low_cnt;

  crpm_core u_crpm_core (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .minipci_mode_i(mini), .aux_power_i(aux),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .eeprom_load_i(eload), .eeprom_ctrl_i(ectrl),
    .second_interrupt_pin_i(line), .second_interrupt_pin_o(cr_o), .second_interrupt_pin_oe_n_o(oe_n),
    .fn1_irq_i(irq), .wake_src_i(wake), .pme_o(pme_o), .pme_oe_n_o(pme_oe_n), .protect_o(prot));
  crpm_host u_crpm_host (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .dev_oe_n_i(oe_n), .line_o(line),
    .done_o(done), .blocked_o(blk), .lat_o(lat));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (oe_n === 1'b0) low_cnt++;

  task automatic complete_run;
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    // one idle edge lets a write land before the caller looks at what it changed
    @(posedge clk_i);
    if (n == 20) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic attempt(input logic exp_blk);
    int n;
    low_cnt = 0;
    @(posedge clk_i) req <= 1'b1;
    @(posedge clk_i) req <= 1'b0;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (done === 1'b1) break;
    end
    if (n < 20) begin
      repeat (6) @(posedge clk_i);
      check({31'h0, blk}, {31'h0, exp_blk});
      check(low_cnt, exp_blk ? 32'h2 : 32'h0);
      if (exp_blk) check({28'h0, lat}, 32'h2);
    end else begin
      fails++;
      complete_run();
    end
  endtask

  task automatic pulse(input crpm_wake_t w);
    @(posedge clk_i) wake <= w;
    @(posedge clk_i) wake <= '0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic pci_reset;
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  initial begin
    rst_i    = 1'b1;
    por_i    = 1'b1;
    mini     = 1'b1;
    aux      = 1'b0;
    cyc      = 1'b0;
    stb      = 1'b0;
    we       = 1'b0;
    eload    = 1'b0;
    irq      = 1'b0;
    req      = 1'b0;
    adr      = 8'h00;
    sel      = 4'h0;
    wdat     = 32'h0;
    ectrl    = 2'h0;
    wake     = '0;
    fails    = 0;
    compares = 0;
    low_cnt  = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    @(posedge clk_i);
    check({31'h0, prot}, 32'h1);
    wb(1'b0, STATUS_OFS, 32'h0);
    // idle sequencer, pm armed, protection on, no drive, minipci strap, main power
    check(rd, 32'h0000_000a);
    wb(1'b0, MISC_CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, PMC_CAP_OFS, 32'h0);
    check({31'h0, rd[D3COLD_CAP_BIT]}, 32'h1);
    wb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, PMCSR0_OFS, 32'h8000);
    wb(1'b1, PMCSR1_OFS, 32'h8000);
    attempt(1'b1);
    attempt(1'b1);
    // a host that never deasserts: no drive, and no interrupt on the pin either
    irq     <= 1'b1;
    low_cnt = 0;
    repeat (20) @(posedge clk_i);
    check(low_cnt, 32'h0);
    irq <= 1'b0;
    wb(1'b1, MISC_CTRL_OFS, 32'h4000_0000);
    attempt(1'b0);
    wb(1'b1, MISC_CTRL_OFS, 32'h6000_0000);
    attempt(1'b0);
    wb(1'b1, MISC_CTRL_OFS, 32'h0);
    attempt(1'b1);
    @(posedge clk_i);
    ectrl <= 2'h2;
    eload <= 1'b1;
    @(posedge clk_i);
    eload <= 1'b0;
    wb(1'b0, MISC_CTRL_OFS, 32'h0);
    check(rd, 32'h4000_0000);
    wb(1'b1, MISC_CTRL_OFS, 32'h2000_0000);
    attempt(1'b1);
    wb(1'b1, PMCSR0_OFS, {30'h0, PS_D3});
    attempt(1'b1);
    wb(1'b1, PMCSR1_OFS, 32'h0000_0102);
    attempt(1'b0);
    pulse(crpm_wake_t'(9'h001));
    check({31'h0, pme_oe_n}, 32'h0);
    check({31'h0, prot}, 32'h1);
    attempt(1'b1);
    wb(1'b1, PMCSR1_OFS, 32'h0000_0100);
    check({31'h0, pme_oe_n}, 32'h0);
    wb(1'b1, PMCSR1_OFS, 32'h0000_0102);
    attempt(1'b1);
    wb(1'b1, PMCSR1_OFS, 32'h0000_8102);
    check({31'h0, pme_oe_n}, 32'h1);
    wb(1'b1, PMCSR0_OFS, 32'h0);
    wb(1'b1, PMCSR1_OFS, 32'h0000_0100);
    wb(1'b1, PMCSR0_OFS, 32'h0000_0003);
    wb(1'b1, PMCSR1_OFS, 32'h0000_0102);
    attempt(1'b0);
    aux <= 1'b1;
    wb(1'b1, PMCSR0_OFS, 32'h0000_0103);
    // on aux power a clear-to-send edge must not wake function 0
    pulse(crpm_wake_t'(9'h020));
    check({31'h0, pme_oe_n}, 32'h1);
    pulse(crpm_wake_t'(9'h002));
    check({31'h0, pme_oe_n}, 32'h0);
    pci_reset();
    check({31'h0, pme_oe_n}, 32'h0);
    wb(1'b0, PMCSR0_OFS, 32'h0);
    check(rd, 32'h0000_8100);
    mini <= 1'b0;
    pci_reset();
    check({31'h0, pme_oe_n}, 32'h1);
    wb(1'b0, PMC_CAP_OFS, 32'h0);
    check(rd, 32'h0);
    irq <= 1'b1;
    repeat (2) @(posedge clk_i);
    check({31'h0, oe_n}, 32'h0);
    check({30'h0, cr_o, pme_o}, 32'h0);
    complete_run();
  end
endmodule // crpm_core_bench
